// ---- verilog/epfa_params.svh ----
// epfa_params.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by every epfa design file except the package; definitions only
`ifndef EPFA_PARAMS_SVH
`define EPFA_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EPFA_OFF_CTRL 8'h00
`define EPFA_OFF_STATUS 8'h04
`define EPFA_OFF_WORD_IDX 8'h08
`define EPFA_OFF_WORD_DATA 8'h0C
`define EPFA_OFF_CMD 8'h10
`define EPFA_OFF_ANC_IDX 8'h14
`define EPFA_OFF_ANC_DATA 8'h18
`define EPFA_OFF_PKT_IDX 8'h1C
`define EPFA_OFF_PKT_DATA 8'h20
`define EPFA_OFF_HK_IDX 8'h24
`define EPFA_OFF_HK_DATA 8'h28

// ---------------------------------------------------------------
// packet layout, packet bit numbers
// ---------------------------------------------------------------
`define EPFA_PRM_START 2192
`define EPFA_PRM_WORDS 20
`define EPFA_REC_WORDS 32
`define EPFA_HK_EIGHT_FIRST 20
`define EPFA_HK_EIGHT_WORDS 8
`define EPFA_ANC_SUBADDR 5'h04

// ---------------------------------------------------------------
// parameter field starts (packet bits) and range limits
// ---------------------------------------------------------------
`define EPFA_P_APID 2208
`define EPFA_P_HBMON 2319
`define EPFA_P_QLOOK 2335
`define EPFA_P_CALDLY 2336
`define EPFA_P_LOCK 2351
`define EPFA_P_DOORHTR 2473
`define EPFA_APID_MIN 11'h054
`define EPFA_APID_MAX 11'h07F
`define EPFA_DLY_MAX 7'h32

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define EPFA_RST_APID 11'h054
`define EPFA_CLK_HZ 10000000
`define EPFA_HTR_SEC 180
`define EPFA_HTR_CYC (`EPFA_CLK_HZ * `EPFA_HTR_SEC)
`define EPFA_TEST_WORD 16'hA5C3

`endif

// ---- verilog/epfa_pkg.sv ----
// epfa_pkg.sv: types shared by the packet field assembler
// assumes nothing beyond a SystemVerilog compiler
package epfa_pkg;
   // operating modes, encoding as commanded
   typedef enum logic [2:0] {
      EPFA_SURVIVAL = 3'h0,
      EPFA_SAFE = 3'h1,
      EPFA_STANDBY = 3'h2,
      EPFA_OUTGAS = 3'h3,
      EPFA_SCIENCE = 3'h4,
      EPFA_TEST = 3'h5
   } epfa_mode_t;

   // command codes written to the command register
   typedef enum logic [3:0] {
      EPFA_CMD_NONE = 4'h0,
      EPFA_CMD_QLOOK_SET = 4'h1,
      EPFA_CMD_QLOOK_CLR = 4'h2,
      EPFA_CMD_HBMON_ON = 4'h3,
      EPFA_CMD_HBMON_OFF = 4'h4,
      EPFA_CMD_UNLOCK = 4'h5,
      EPFA_CMD_DOOR_HTR_ON = 4'h6,
      EPFA_CMD_DOOR_HTR_OFF = 4'h7
   } epfa_cmd_t;

   // parameter transfer states, gray along idle-send-done
   typedef enum logic [1:0] {
      EPFA_ST_IDLE = 2'b00,
      EPFA_ST_SEND = 2'b01,
      EPFA_ST_DONE = 2'b11
   } epfa_state_t;
endpackage : epfa_pkg

// ---- verilog/epfa_record_store.sv ----
// epfa_record_store.sv: current/prior 512-bit record pair, rotated per scan
// assumes words arrive as 16-bit words 0..31, word 0 holds bits 0..15 msb first
`timescale 1ns/10ps
`include "epfa_params.svh"
module epfa_record_store (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic wr_i,
   input wire logic [4:0] wr_idx_i,
   input wire logic [15:0] wr_data_i,
   input wire logic rotate_i,
   // read side, 6-bit index: bit 5 picks prior
   input wire logic [5:0] rd_idx_i,
   output logic [15:0] rd_data_o
);
   logic [15:0] cur_ff [0:`EPFA_REC_WORDS-1];
   logic [15:0] pri_ff [0:`EPFA_REC_WORDS-1];

   // ---------------------------------------------------------------
   // storage: rotation copies current into prior before new fill
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < `EPFA_REC_WORDS; i++) begin
         if (rst_i) begin
            cur_ff[i] <= 16'h0000;
            pri_ff[i] <= 16'h0000;
         end else if (rotate_i) begin
            pri_ff[i] <= cur_ff[i];
         end else if (wr_i && wr_idx_i == 5'(i)) begin
            cur_ff[i] <= wr_data_i;
         end
      end
   end

   // read mux, copied verbatim, never interpreted
   always_comb begin
      rd_data_o = rd_idx_i[5] ? pri_ff[rd_idx_i[4:0]] : cur_ff[rd_idx_i[4:0]];
   end
endmodule : epfa_record_store

// ---- verilog/epfa_housekeeping_gate.sv ----
// epfa_housekeeping_gate.sv: gates the tail regions of a housekeeping frame
// assumes major cycle number arrives with each frame word 0
`timescale 1ns/10ps
`include "epfa_params.svh"
module epfa_housekeeping_gate (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // frame word in
   input wire logic [4:0] word_idx_i,
   input wire logic [15:0] word_i,
   input wire logic [5:0] major_cycle_i,
   // gated word out
   output logic [15:0] word_o,
   output logic [5:0] last_eight_cycle_o
);
   logic [15:0] eight_ff [0:`EPFA_HK_EIGHT_WORDS-1];
   logic is_eight;
   logic refresh;

   assign is_eight = word_idx_i >= 5'(`EPFA_HK_EIGHT_FIRST)
      && word_idx_i < 5'(`EPFA_HK_EIGHT_FIRST + `EPFA_HK_EIGHT_WORDS);
   // eight-second region only refreshes on every eighth major cycle
   assign refresh = major_cycle_i[2:0] == 3'h0; // R1

   // ---------------------------------------------------------------
   // eight-second hold
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < `EPFA_HK_EIGHT_WORDS; i++) begin
         if (rst_i) begin
            eight_ff[i] <= 16'h0000;
         end else if (is_eight && refresh
                      && word_idx_i == 5'(`EPFA_HK_EIGHT_FIRST + i)) begin
            eight_ff[i] <= word_i; // R1
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_eight_cycle_o <= 6'h00;
      end else if (is_eight && refresh) begin
         last_eight_cycle_o <= major_cycle_i;
      end
   end

   // sixty-five-second and other words pass fresh each cycle; eight-second words between refreshes come from the hold
   always_comb begin
      if (is_eight && !refresh) begin
         word_o = eight_ff[word_idx_i[2:0] + 3'h4]; // R1
      end else begin
         word_o = word_i; // R2
      end
   end
endmodule : epfa_housekeeping_gate

// ---- verilog/epfa_assembler.sv ----
// epfa_assembler.sv: engineering packet data field assembler with wishbone regs
// assumes a classic wishbone master on clk_i; formatter pulls words by strobe
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
`include "epfa_params.svh"

// Overview of operation
// [R1] eight-second region repeats every eighth cycle
// [R2] sixty-five-second tail unique each cycle
// [R3] decoder reads major cycle first
// [R4] ancillary from subaddress 4, copied unused
// [R5] current ancillary at bits 1168-1679
// [R6] prior ancillary at bits 1680-2191
// [R7] ancillary header fields in fixed order
// [R8] attitude fields 12-bit, 4-bit reserved before
// [R9] 3-bit mode at 2204, test emits pattern; code swaps only words whose bit w[0] is clear
// [R10] rate bit 2207: 1 day, 0 night
// [R11] heater set point 12 bits at 2192
// [R12] app identifier 11 bits, 084-127
// [R13] packet type bit 2223, test fixed
// [R14] quick-look bit 2335 set/clear commands
// [R15] view delays 7-bit, 0 to 50
// [R16] encoder delta 14-bit at 2384
// [R17] photoconductive offset 16-bit at 2400
// [R18] commander keeps injection steps in limit
// [R19] door heater active low, 3 min off
// [R20] heartbeat monitor bit at 2319
// [R21] table select bits: 1 normal
// [R22] unlatch only right after unlock
// [R23] parameter block sent as twenty words
// [R24] word bit 0 is msb
// [R25] contiguous packing, shared bits track last
module epfa_assembler (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // ancillary data from the 1553 remote terminal
   input wire logic anc_wr_i,
   input wire logic [4:0] anc_subaddr_i,
   input wire logic [4:0] anc_idx_i,
   input wire logic [15:0] anc_data_i,
   // formatter side
   input wire logic scan_start_i,
   output logic prm_valid_o,
   output logic [15:0] prm_word_o,
   output logic [4:0] prm_idx_o,
   output logic door_htr_n_o,
   output logic door_unlatch_o
);
   import epfa_pkg::*;

   localparam logic [31:0] HTR_CYC = 32'(`EPFA_HTR_CYC);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [15:0] prm_ff [0:`EPFA_PRM_WORDS-1];
   logic [4:0] word_idx_ff;
   logic [4:0] anc_idx_ff;
   logic [5:0] pkt_idx_ff;
   logic [5:0] hk_idx_ff;
   logic [15:0] hk_mem [0:`EPFA_REC_WORDS-1];
   logic qlook_ff;
   logic hbmon_ff;
   logic unlock_ff;
   logic door_htr_n_ff;
   logic door_unlatch_ff;
   logic [31:0] htr_cnt_ff;
   logic bad_apid_ff;
   logic bad_dly_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   epfa_state_t st_ff;
   epfa_state_t nxt_st;
   logic [4:0] tx_idx_ff;
   logic prm_valid_ff;
   logic [15:0] prm_word_ff;
   logic [4:0] prm_idx_ff;
   logic [15:0] anc_rd;
   logic [15:0] hk_gated;
   logic [5:0] hk_cycle;
   logic anc_take;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // packet bit to word index in the parameter block
   function automatic logic [4:0] prm_word(input int pkt_bit);
      prm_word = 5'((pkt_bit - `EPFA_PRM_START) / 16); // R25
   endfunction : prm_word

   // packet bit to position in 16-bit word, lsb numbered 0
   function automatic logic [3:0] prm_pos(input int pkt_bit);
      prm_pos = 4'(15 - ((pkt_bit - `EPFA_PRM_START) % 16)); // R24
   endfunction : prm_pos

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic bus_wr;
   logic bus_rd;
   assign bus_wr = cyc_i && stb_i && we_i && !ack_ff && sel_i[0] && sel_i[1];
   assign bus_rd = cyc_i && stb_i && !we_i && !ack_ff;

   // one wait-free ack, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= cyc_i && stb_i && !ack_ff;
      end
   end

   // ---------------------------------------------------------------
   // ancillary capture, subaddress 4 only, never interpreted
   // ---------------------------------------------------------------
   assign anc_take = anc_wr_i && anc_subaddr_i == `EPFA_ANC_SUBADDR; // R4

   epfa_record_store u_anc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(anc_take),
      .wr_idx_i(anc_idx_i),
      .wr_data_i(anc_data_i),
      .rotate_i(scan_start_i), // R6
      .rd_idx_i(pkt_idx_ff),
      .rd_data_o(anc_rd)
   );

   // housekeeping frame kept whole; tail regions gated on write
   epfa_housekeeping_gate u_hk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .word_idx_i(hk_idx_ff[4:0]),
      .word_i(dat_i[15:0]),
      .major_cycle_i(hk_mem[0][15:10]), // R3
      .word_o(hk_gated),
      .last_eight_cycle_o(hk_cycle)
   );

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < `EPFA_REC_WORDS; i++) begin
         if (rst_i) begin
            hk_mem[i] <= 16'h0000;
         end else if (bus_wr && adr_i == `EPFA_OFF_HK_DATA && hk_idx_ff[4:0] == 5'(i)) begin
            hk_mem[i] <= hk_gated; // R1 R2
         end
      end
   end

   // ---------------------------------------------------------------
   // index registers, packet index auto increments on ancillary data read, housekeeping index on data write
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_idx_ff <= 5'h00;
         pkt_idx_ff <= 6'h00;
         hk_idx_ff <= 6'h00;
         anc_idx_ff <= 5'h00;
      end else begin
         if (bus_wr && adr_i == `EPFA_OFF_WORD_IDX) begin
            word_idx_ff <= dat_i[4:0];
         end
         if (bus_wr && adr_i == `EPFA_OFF_PKT_IDX) begin
            pkt_idx_ff <= dat_i[5:0];
         end else if (bus_rd && adr_i == `EPFA_OFF_ANC_DATA) begin
            pkt_idx_ff <= pkt_idx_ff + 6'h01;
         end
         if (bus_wr && adr_i == `EPFA_OFF_HK_IDX) begin
            hk_idx_ff <= dat_i[5:0];
         end else if (bus_wr && adr_i == `EPFA_OFF_HK_DATA) begin
            hk_idx_ff <= hk_idx_ff + 6'h01;
         end
         if (anc_take) begin
            anc_idx_ff <= anc_idx_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // parameter block words written by software, range checked
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bad_apid_ff <= 1'b0;
         bad_dly_ff <= 1'b0;
      end else if (bus_wr && adr_i == `EPFA_OFF_WORD_DATA) begin
         if (word_idx_ff == prm_word(`EPFA_P_APID)) begin
            // out of range identifiers are refused and flagged
            bad_apid_ff <= dat_i[15:5] < `EPFA_APID_MIN || dat_i[15:5] > `EPFA_APID_MAX; // R12
         end
         if (word_idx_ff == prm_word(`EPFA_P_CALDLY)) begin
            bad_dly_ff <= dat_i[15:9] > `EPFA_DLY_MAX; // R15
         end
      end
   end

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < `EPFA_PRM_WORDS; i++) begin
         if (rst_i) begin
            prm_ff[i] <= (i == 1) ? {`EPFA_RST_APID, 5'h00} : 16'h0000;
         end else if (bus_wr && adr_i == `EPFA_OFF_WORD_DATA && word_idx_ff == 5'(i)) begin
            if (i == 1 && (dat_i[15:5] < `EPFA_APID_MIN || dat_i[15:5] > `EPFA_APID_MAX)) begin
               prm_ff[i] <= {prm_ff[i][15:5], dat_i[4:0]}; // R12
            end else if (i == 9 && dat_i[15:9] > `EPFA_DLY_MAX) begin
               prm_ff[i] <= {prm_ff[i][15:9], dat_i[8:0]}; // R15
            end else begin
               // fields sit back to back at their start bits
               prm_ff[i] <= dat_i[15:0]; // R11 R9 R10 R13 R16 R17 R21 R25
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // commands for shared bits, lock and door heater
   // ---------------------------------------------------------------
   epfa_cmd_t cmd;
   assign cmd = (bus_wr && adr_i == `EPFA_OFF_CMD) ? epfa_cmd_t'(dat_i[3:0]) : EPFA_CMD_NONE;

   // latest of set and clear wins, no priority needed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         qlook_ff <= 1'b0;
         hbmon_ff <= 1'b0;
      end else begin
         if (cmd == EPFA_CMD_QLOOK_SET) begin
            qlook_ff <= 1'b1; // R14
         end else if (cmd == EPFA_CMD_QLOOK_CLR) begin
            qlook_ff <= 1'b0; // R14
         end
         if (cmd == EPFA_CMD_HBMON_ON) begin
            hbmon_ff <= 1'b1; // R20
         end else if (cmd == EPFA_CMD_HBMON_OFF) begin
            hbmon_ff <= 1'b0; // R20
         end
      end
   end

   // unlock arms only the very next command
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unlock_ff <= 1'b0;
      end else if (cmd != EPFA_CMD_NONE) begin
         unlock_ff <= cmd == EPFA_CMD_UNLOCK; // R22
      end
   end

   // heater is active low; timer forces it off after three minutes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         door_htr_n_ff <= 1'b1;
         door_unlatch_ff <= 1'b0;
         htr_cnt_ff <= 32'h0000_0000;
      end else begin
         door_unlatch_ff <= 1'b0;
         if (cmd == EPFA_CMD_DOOR_HTR_ON && unlock_ff) begin
            door_htr_n_ff <= 1'b0; // R19 R22
            door_unlatch_ff <= 1'b1; // R22
            htr_cnt_ff <= 32'h0000_0000;
         end else if (cmd == EPFA_CMD_DOOR_HTR_OFF) begin
            door_htr_n_ff <= 1'b1; // R19
         end else if (!door_htr_n_ff) begin
            if (htr_cnt_ff >= HTR_CYC - 32'h0000_0001) begin
               door_htr_n_ff <= 1'b1; // R19
            end else begin
               htr_cnt_ff <= htr_cnt_ff + 32'h0000_0001;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // per-scan transfer of twenty words to the formatter
   // ---------------------------------------------------------------
   always_comb begin
      case (st_ff)
         EPFA_ST_IDLE: nxt_st = scan_start_i ? EPFA_ST_SEND : EPFA_ST_IDLE;
         EPFA_ST_SEND: nxt_st = (tx_idx_ff == 5'(`EPFA_PRM_WORDS - 1)) ? EPFA_ST_DONE : EPFA_ST_SEND;
         EPFA_ST_DONE: nxt_st = EPFA_ST_IDLE;
         default: nxt_st = EPFA_ST_IDLE;
      endcase
   end

   // shared bits merged into their words on the way out
   function automatic logic [15:0] out_word(input logic [4:0] i, input logic [15:0] w);
      logic [15:0] r;
      r = w;
      if (i == prm_word(`EPFA_P_HBMON)) begin
         r[prm_pos(`EPFA_P_HBMON)] = hbmon_ff; // R20 R25
      end
      if (i == prm_word(`EPFA_P_QLOOK)) begin
         r[prm_pos(`EPFA_P_QLOOK)] = qlook_ff; // R14 R25
      end
      if (i == prm_word(`EPFA_P_LOCK)) begin
         r[prm_pos(`EPFA_P_LOCK)] = unlock_ff; // R22
      end
      if (i == prm_word(`EPFA_P_DOORHTR)) begin
         r[prm_pos(`EPFA_P_DOORHTR)] = door_htr_n_ff; // R19
      end
      // test mode swaps each word whose bit w[0] is clear for a fixed link pattern
      if (w[0] == 1'b0 && epfa_mode_t'(prm_ff[0][3:1]) == EPFA_TEST) begin
         r = `EPFA_TEST_WORD; // R9
      end
      out_word = r;
   endfunction : out_word

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= EPFA_ST_IDLE;
         tx_idx_ff <= 5'h00;
         prm_valid_ff <= 1'b0;
         prm_word_ff <= 16'h0000;
         prm_idx_ff <= 5'h00;
      end else begin
         st_ff <= nxt_st;
         prm_valid_ff <= st_ff == EPFA_ST_SEND; // R23
         prm_idx_ff <= tx_idx_ff;
         prm_word_ff <= out_word(tx_idx_ff, prm_ff[tx_idx_ff]);
         if (st_ff == EPFA_ST_SEND) begin
            tx_idx_ff <= tx_idx_ff + 5'h01; // R23
         end else begin
            tx_idx_ff <= 5'h00;
         end
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_ff <= 32'h0000_0000;
      end else if (bus_rd) begin
         case (adr_i)
            `EPFA_OFF_CTRL: dat_ff <= {16'h0000, prm_ff[0]};
            `EPFA_OFF_STATUS: dat_ff <= {20'h0_0000, hk_cycle, bad_dly_ff, bad_apid_ff,
                                         door_htr_n_ff, unlock_ff, hbmon_ff, qlook_ff};
            `EPFA_OFF_WORD_IDX: dat_ff <= {27'h000_0000, word_idx_ff};
            `EPFA_OFF_WORD_DATA: dat_ff <= {16'h0000, out_word(word_idx_ff, prm_ff[word_idx_ff])};
            `EPFA_OFF_ANC_IDX: dat_ff <= {27'h000_0000, anc_idx_ff};
            `EPFA_OFF_ANC_DATA: dat_ff <= {16'h0000, anc_rd}; // R5 R6 R7 R8
            `EPFA_OFF_PKT_IDX: dat_ff <= {26'h000_0000, pkt_idx_ff};
            `EPFA_OFF_HK_IDX: dat_ff <= {26'h000_0000, hk_idx_ff};
            `EPFA_OFF_HK_DATA: dat_ff <= {16'h0000, hk_mem[hk_idx_ff[4:0]]};
            default: dat_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign dat_o = dat_ff;
   assign ack_o = ack_ff;
   assign prm_valid_o = prm_valid_ff;
   assign prm_word_o = prm_word_ff;
   assign prm_idx_o = prm_idx_ff;
   assign door_htr_n_o = door_htr_n_ff;
   assign door_unlatch_o = door_unlatch_ff;
endmodule : epfa_assembler

// ---- verification/epfa_assembler_properties.sv ----
// epfa_assembler_properties.sv: port checks of the assembler
// assumes a bind to epfa_assembler on its single clock
`timescale 1ns/10ps
module epfa_chk (
   // clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // formatter and door
   input wire logic scan_start_i,
   input wire logic prm_valid_o,
   input wire logic [4:0] prm_idx_o,
   input wire logic door_htr_n_o,
   input wire logic door_unlatch_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // request taken only while ack is low
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   // last of the twenty words
   sequence s_last;
      prm_valid_o && prm_idx_o == 5'h13;
   endsequence
   ack_answer_a: assert property (s_take |=> ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held");
   ack_idle_a: assert property (!stb_i |=> !ack_o)
      else $error("ack unasked");
   burst_first_a: assert property ($rose(prm_valid_o) |-> prm_idx_o == 5'h00 && $past(scan_start_i, 2))
      else $error("burst start wrong");
   burst_step_a: assert property (prm_valid_o && prm_idx_o != 5'h13 |=> prm_valid_o && prm_idx_o == $past(prm_idx_o) + 5'h01)
      else $error("burst word skipped");
   burst_end_a: assert property (s_last |=> !prm_valid_o)
      else $error("burst too long");
   unlatch_heat_a: assert property (door_unlatch_o |-> !door_htr_n_o)
      else $error("unlatch without heater");
   unlatch_pulse_a: assert property (door_unlatch_o |=> !door_unlatch_o)
      else $error("unlatch held");
   heater_off_a: assert property ($rose(door_htr_n_o) |-> $past(stb_i))
      else $error("heater off unasked");
endmodule : epfa_chk

bind epfa_assembler epfa_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .scan_start_i(scan_start_i), .prm_valid_o(prm_valid_o),
   .prm_idx_o(prm_idx_o), .door_htr_n_o(door_htr_n_o), .door_unlatch_o(door_unlatch_o));

// ---- verification/epfa_anc_src.sv ----
// epfa_anc_src.sv: spacecraft side sending ancillary records
// assumes the caller waits for send to return
`timescale 1ns/10ps
module epfa_anc_src (
   // clock
   input wire logic clk_i,
   // ancillary word stream
   output logic wr_o = 1'b0,
   output logic [4:0] sa_o = 5'h00,
   output logic [4:0] idx_o = 5'h00,
   output logic [15:0] data_o = 16'h0000
);
   // one whole record; data scrambles after it so stale words never match
   task automatic send(input logic [4:0] sa, input logic [15:0] base);
      for (int i = 0; i < 32; i++) begin
         @(posedge clk_i);
         wr_o <= 1'b1;
         sa_o <= sa;
         idx_o <= i[4:0];
         data_o <= base + 16'(i);
      end
      @(posedge clk_i);
      wr_o <= 1'b0;
      data_o <= ~data_o;
   endtask : send
endmodule : epfa_anc_src

// ---- verification/epfa_tb_top.sv ----
// epfa_tb_top.sv: bus and formatter tests of the assembler
// assumes the checker binds itself and the source feeds the 1553 side
`timescale 1ns/10ps
`include "epfa_params.svh"
module engineering_packet_field_assembler_tb_top;
   import epfa_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic scan_start_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [15:0] wd = 16'h0000;
   logic [31:0] dat_o;
   logic ack_o, prm_valid_o, htr_n, anc_wr, unl;
   logic [4:0] sa, ai, prm_idx_o;
   logic [15:0] ad, prm_word_o, rd;
   logic [15:0] cap [20];
   logic [10:0] av [4] = '{11'h054, 11'h053, 11'h07F, 11'h080};
   int bad_count = 0;
   int compares = 0;
   int unl_n = 0;
   epfa_assembler dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i({16'h0000, wd}), .dat_o(dat_o),
      .ack_o(ack_o), .anc_wr_i(anc_wr), .anc_subaddr_i(sa), .anc_idx_i(ai),
      .anc_data_i(ad), .scan_start_i(scan_start_i), .prm_valid_o(prm_valid_o),
      .prm_word_o(prm_word_o), .prm_idx_o(prm_idx_o), .door_htr_n_o(htr_n),
      .door_unlatch_o(unl));
   epfa_anc_src u_anc (.clk_i(clk_i), .wr_o(anc_wr), .sa_o(sa), .idx_o(ai), .data_o(ad));
   // 100 ns clock
   initial forever #50 clk_i = ~clk_i;
   // formatter words kept by index
   always @(posedge clk_i) if (prm_valid_o) cap[prm_idx_o] <= prm_word_o;
   always @(posedge clk_i) if (unl === 1'b1) unl_n <= unl_n + 1;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      wd <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o[15:0];
      if (n == 50) bad_count++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      wb(1'b0, a, 16'h0000);
      chk(rd, exp);
   endtask : rchk
   task automatic wword(input logic [4:0] i, input logic [15:0] d);
      wb(1'b1, `EPFA_OFF_WORD_IDX, {11'h000, i});
      wb(1'b1, `EPFA_OFF_WORD_DATA, d);
   endtask : wword
   task automatic wchk(input logic [4:0] i, input logic [15:0] exp);
      wb(1'b1, `EPFA_OFF_WORD_IDX, {11'h000, i});
      rchk(`EPFA_OFF_WORD_DATA, exp);
   endtask : wchk
   task automatic hk(input logic [5:0] i, input logic [15:0] d);
      wb(1'b1, `EPFA_OFF_HK_IDX, {10'h000, i});
      wb(1'b1, `EPFA_OFF_HK_DATA, d);
   endtask : hk
   task automatic cmd(input epfa_cmd_t c);
      wb(1'b1, `EPFA_OFF_CMD, {12'h000, c});
   endtask : cmd
   // heater level once the command has landed
   task automatic hchk(input logic exp);
      repeat (2) @(negedge clk_i);
      chk({15'h0000, htr_n}, {15'h0000, exp});
   endtask : hchk
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   // main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({15'h0000, htr_n}, 16'h0001);
      wchk(5'h01, {`EPFA_RST_APID, 5'h00});
      for (int m = 0; m < 6; m++) begin
         wword(5'h00, {12'hABC, m[2:0], 1'b1});
         wchk(5'h00, {12'hABC, m[2:0], 1'b1});
      end
      wword(5'h00, 16'hABC8);
      wchk(5'h00, 16'hABC8);
      // identifier edges: out of range keeps the old value
      for (int i = 0; i < 4; i++) begin
         wword(5'h01, {av[i], 5'h01});
         wchk(5'h01, {av[i & 2], 5'h01});
      end
      wword(5'h09, 16'h6400);
      wword(5'h09, 16'h6600);
      wchk(5'h09, 16'h6400);
      wword(5'h0C, 16'hFFFC);
      wchk(5'h0C, 16'hFFFC);
      wword(5'h0D, 16'h1234);
      wchk(5'h0D, 16'h1234);
      wword(5'h10, 16'h280A);
      wchk(5'h10, 16'h280A);
      hk(6'h14, 16'h1111);
      hk(6'h00, 16'h0400);
      hk(6'h14, 16'h2222);
      hk(6'h1C, 16'h3333);
      wb(1'b1, `EPFA_OFF_HK_IDX, 16'h0014);
      rchk(`EPFA_OFF_HK_DATA, 16'h1111);
      wb(1'b1, `EPFA_OFF_HK_IDX, 16'h001C);
      rchk(`EPFA_OFF_HK_DATA, 16'h3333);
      $display("field tests done");
      for (int i = 0; i < 4; i++) begin
         cmd(epfa_cmd_t'(i + 1));
         wchk(i < 2 ? 5'h08 : 5'h07, {15'h0000, ~i[0]});
      end
      cmd(EPFA_CMD_UNLOCK);
      cmd(EPFA_CMD_QLOOK_SET);
      cmd(EPFA_CMD_DOOR_HTR_ON);
      hchk(1'b1);
      chk(16'(unl_n), 16'h0000);
      cmd(EPFA_CMD_UNLOCK);
      cmd(EPFA_CMD_DOOR_HTR_ON);
      hchk(1'b0);
      chk(16'(unl_n), 16'h0001);
      cmd(EPFA_CMD_DOOR_HTR_OFF);
      hchk(1'b1);
      $display("command tests done");
      u_anc.send(5'h04, 16'h1000);
      u_anc.send(5'h05, 16'h2000);
      wb(1'b1, `EPFA_OFF_PKT_IDX, 16'h0003);
      rchk(`EPFA_OFF_ANC_DATA, 16'h1003);
      @(posedge clk_i);
      scan_start_i <= 1'b1;
      @(posedge clk_i);
      scan_start_i <= 1'b0;
      repeat (24) @(posedge clk_i);
      chk(cap[0], 16'hABC8);
      chk(cap[19], 16'h0000);
      wb(1'b1, `EPFA_OFF_PKT_IDX, 16'h0023);
      rchk(`EPFA_OFF_ANC_DATA, 16'h1003);
      rchk(`EPFA_OFF_ANC_DATA, 16'h1004);
      $display("ancillary tests done");
      end_of_test();
   end
   // hang guard
   initial begin
      #2000000;
      bad_count++;
      end_of_test();
   end
endmodule : engineering_packet_field_assembler_tb_top
